// *** rbf_pkg.sv ***
// Purpose: constants and types for the receive byte framing and interrupt enable block
// Assumes: 32-bit AXI4-Lite register bus, byte-wide registers in the low bits
// Notes:   printed offsets are not all multiples of four, so they are indices

package rbf_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] RBF_IDX_CTRL   = 8'h06;
    localparam logic [7:0] RBF_IDX_INT_EN = 8'h07;
    localparam logic [7:0] RBF_IDX_STAT   = 8'h08;
    localparam logic [7:0] RBF_IDX_DATA_A = 8'h09;
    localparam logic [7:0] RBF_IDX_DATA_B = 8'h0B;
    localparam logic [7:0] RBF_IDX_MASK   = 8'h0C;

    localparam logic [7:0] RBF_CTRL_RST   = 8'h03;
    localparam logic [7:0] RBF_INT_EN_RST = 8'h00;
    localparam logic [7:0] RBF_CTRL_WMASK = 8'h0F;

    // control field positions
    localparam int RBF_CTRL_MODE_BIT = 3;
    localparam int RBF_CTRL_GAP_LSB  = 0;
    localparam int RBF_CTRL_GAP_W    = 3;

    // per channel event positions within a nibble (enable uses all four; status shares only full and eof)
    localparam int RBF_EV_FULL = 0;
    localparam int RBF_EV_EOF  = 1;
    localparam int RBF_EV_OVF  = 2;
    localparam int RBF_EV_UNF  = 3;
    localparam int RBF_CH_W    = 4;

    // status bit positions per channel nibble
    localparam int RBF_ST_VALID = 3;
    localparam int RBF_ST_FLOW  = 2;

    localparam logic [1:0] RBF_RESP_OKAY   = 2'h0;
    localparam logic [1:0] RBF_RESP_SLVERR = 2'h2;

    // receiver bit strobe from one correlator channel
    typedef struct packed {
        logic valid;
        logic data;
    } rbf_bit_s;

    typedef enum logic [1:0] {
        RBF_IDLE,
        RBF_RESP
    } rbf_bus_e;

endpackage

// *** rbf_top.sv ***
// Purpose: receive byte framing, end-of-frame gap detection and receive interrupts
// Assumes: single clock; bit strobes arrive one cycle wide, synchronous to clk
// Notes:   registers reached over AXI4-Lite; serial pins are passed through in bit mode
//
// Added by the designer: the AXI4-Lite interface to the registers.

`timescale 1ns/1ns
`default_nettype none

module rbf_top
    import rbf_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // demodulated bits from the two correlator channels
    input  wire rbf_pkg::rbf_bit_s rx_bit_a,
    input  wire rbf_pkg::rbf_bit_s rx_bit_b,
    // one pulse per bit time, valid or not
    input  wire logic              bit_tick,
    // serial pins towards the host, live only in bit-serial mode
    output logic                   serial_data_pin,
    output logic                   serial_data_valid_pin,
    output logic                   byte_mode_select,
    output logic                   irq
);

    // ---------------- functions ----------------
    function automatic logic [ADDR_W-1:0] idx_addr(input logic [7:0] idx);
        idx_addr = ADDR_W'({idx, 2'b00});
    endfunction

    function automatic logic [7:0] lane_merge(input logic [7:0] old_v,
                                              input logic [31:0] wd,
                                              input logic [3:0] st);
        lane_merge = st[0] ? wd[7:0] : old_v;
    endfunction

    // ---------------- registers ----------------
    logic [7:0] ctrl_r;
    logic [7:0] int_en_r;
    logic [7:0] stat_r;
    logic [7:0] stat_nxt;
    logic [7:0] data_a_r;
    logic [7:0] data_b_r;
    logic [1:0] full_r;
    logic [1:0] valid_all_r;

    assign byte_mode_select = ctrl_r[RBF_CTRL_MODE_BIT];
    wire [RBF_CTRL_GAP_W-1:0] gap_len = ctrl_r[RBF_CTRL_GAP_LSB +: RBF_CTRL_GAP_W];

    // ---------------- AXI4-Lite write path ----------------
    logic              aw_held_r;
    logic              w_held_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    wire               aw_fire = s_axi_awvalid && s_axi_awready;
    wire               w_fire  = s_axi_wvalid && s_axi_wready;
    wire               aw_have = aw_held_r || aw_fire;
    wire               w_have  = w_held_r || w_fire;
    wire               wr_do   = aw_have && w_have;
    wire [ADDR_W-1:0]  wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0]        wr_data = w_held_r ? w_data_r : s_axi_wdata;
    wire [3:0]         wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;

    wire wr_ctrl  = wr_do && (wr_addr == idx_addr(RBF_IDX_CTRL));
    wire wr_en    = wr_do && (wr_addr == idx_addr(RBF_IDX_INT_EN));
    wire wr_stat  = wr_do && (wr_addr == idx_addr(RBF_IDX_STAT));
    wire wr_known = wr_ctrl || wr_en || wr_stat;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= '0;
            w_strb_r  <= '0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RBF_RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            aw_held_r <= aw_have && !wr_do;
            w_held_r  <= w_have && !wr_do;
            if (wr_do) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_known ? RBF_RESP_OKAY : RBF_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // reserved control bits are kept at zero whatever is written
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r   <= RBF_CTRL_RST;
            int_en_r <= RBF_INT_EN_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= lane_merge(ctrl_r, wr_data, wr_strb) & RBF_CTRL_WMASK;
            end
            if (wr_en) begin
                int_en_r <= lane_merge(int_en_r, wr_data, wr_strb);
            end
        end
    end

    // ---------------- AXI4-Lite read path ----------------
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    wire ar_fire  = s_axi_arvalid && s_axi_arready;
    wire rd_ctrl  = s_axi_araddr == idx_addr(RBF_IDX_CTRL);
    wire rd_en    = s_axi_araddr == idx_addr(RBF_IDX_INT_EN);
    wire rd_stat  = s_axi_araddr == idx_addr(RBF_IDX_STAT);
    wire rd_da    = s_axi_araddr == idx_addr(RBF_IDX_DATA_A);
    wire rd_db    = s_axi_araddr == idx_addr(RBF_IDX_DATA_B);
    wire rd_known = rd_ctrl || rd_en || rd_stat || rd_da || rd_db;

    // side effects of reads happen at the address handshake
    wire rd_stat_ev = ar_fire && rd_stat;
    wire rd_da_ev   = ar_fire && rd_da;
    wire rd_db_ev   = ar_fire && rd_db;

    wire [7:0] rd_mux = rd_ctrl ? ctrl_r :
                        rd_en   ? int_en_r :
                        rd_stat ? stat_r :
                        rd_da   ? data_a_r :
                        rd_db   ? data_b_r : 8'h00;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= RBF_RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_r <= 1'b1;
            rdata_r  <= {24'h000000, rd_mux};
            rresp_r  <= rd_known ? RBF_RESP_OKAY : RBF_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ---------------- receive framing, one per channel ----------------
    rbf_bit_s   rx_bit [2];
    logic [1:0] load_ev;
    logic [1:0] eof_ev;
    logic [1:0] rd_ev;
    logic [7:0] load_byte [2];
    logic [1:0] load_full;

    assign rx_bit[0] = rx_bit_a;
    assign rx_bit[1] = rx_bit_b;
    assign rd_ev     = {rd_db_ev, rd_da_ev};

    // bit-serial path: received bits appear on the pins only when byte mode is off
    assign serial_data_pin       = !byte_mode_select && rx_bit_a.data;
    assign serial_data_valid_pin = !byte_mode_select && rx_bit_a.valid && bit_tick;

    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic [7:0]                shift_r;
        logic [3:0]                cnt_r;
        logic                      armed_r;
        logic [RBF_CTRL_GAP_W:0]   gap_r;

        wire got_bit   = bit_tick && rx_bit[c].valid;
        wire miss_bit  = bit_tick && !rx_bit[c].valid;
        // gap counts invalid bit times; event once count exceeds the field
        wire gap_done  = armed_r && miss_bit && (gap_r >= {1'b0, gap_len});
        wire [7:0] sh_nxt = {shift_r[6:0], rx_bit[c].data};
        wire byte_done = got_bit && (cnt_r == 4'h7);

        // only byte mode loads assembled bytes; serial mode still shifts but leaves the data registers alone
        assign eof_ev[c]    = byte_mode_select && gap_done && (cnt_r != 4'h0);
        assign load_ev[c]   = (byte_mode_select && byte_done) || eof_ev[c];
        assign load_byte[c] = byte_done ? sh_nxt : shift_r;
        assign load_full[c] = byte_done;

        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                shift_r <= '0;
                cnt_r   <= '0;
                armed_r <= 1'b0;
                gap_r   <= '0;
            end else if (got_bit) begin
                armed_r <= 1'b1;
                gap_r   <= '0;
                // a finished byte leaves nothing behind, so a later partial byte is clean
                shift_r <= byte_done ? '0 : sh_nxt;
                cnt_r   <= byte_done ? 4'h0 : cnt_r + 4'h1;
            end else if (gap_done) begin
                armed_r <= 1'b0;
                gap_r   <= '0;
                cnt_r   <= '0;
                shift_r <= '0;
            end else if (miss_bit && armed_r) begin
                gap_r <= gap_r + 1'b1;
            end
        end
    end

    // frame end with no pending partial byte still counts as a frame event
    logic [1:0] frame_end;
    assign frame_end[0] = byte_mode_select && g_ch[0].gap_done;
    assign frame_end[1] = byte_mode_select && g_ch[1].gap_done;

    // ---------------- data registers and status ----------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            data_a_r    <= '0;
            data_b_r    <= '0;
            full_r      <= '0;
            valid_all_r <= '0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (load_ev[c]) begin
                    full_r[c]      <= 1'b1;
                    valid_all_r[c] <= load_full[c];
                end else if (rd_ev[c]) begin
                    full_r[c] <= 1'b0;
                end
            end
            if (load_ev[0]) begin
                data_a_r <= load_byte[0];
            end
            if (load_ev[1]) begin
                data_b_r <= load_byte[1];
            end
        end
    end

    // sticky events: set wins over the clear from a status read
    always_comb begin
        stat_nxt = stat_r;
        for (int c = 0; c < 2; c++) begin
            if (rd_stat_ev) begin
                stat_nxt[c*RBF_CH_W + RBF_EV_EOF]  = 1'b0;
                stat_nxt[c*RBF_CH_W + RBF_ST_FLOW] = 1'b0;
                stat_nxt[c*RBF_CH_W + RBF_EV_FULL] = 1'b0;
            end
            if (wr_stat) begin
                stat_nxt[c*RBF_CH_W +: RBF_CH_W] = stat_nxt[c*RBF_CH_W +: RBF_CH_W]
                    & ~wr_data[c*RBF_CH_W +: RBF_CH_W];
            end
            if (load_ev[c]) begin
                stat_nxt[c*RBF_CH_W + RBF_EV_FULL] = 1'b1;
            end
            if (frame_end[c]) begin
                stat_nxt[c*RBF_CH_W + RBF_EV_EOF] = 1'b1;
            end
            if ((load_ev[c] && full_r[c] && !rd_ev[c]) || (rd_ev[c] && !full_r[c])) begin
                stat_nxt[c*RBF_CH_W + RBF_ST_FLOW] = 1'b1;
            end
            stat_nxt[c*RBF_CH_W + RBF_ST_VALID] = valid_all_r[c];
        end
    end

    // separate pending flags so each enable bit sees its own cause
    logic [7:0] pend_r;
    logic [7:0] pend_nxt;
    always_comb begin
        pend_nxt = pend_r;
        for (int c = 0; c < 2; c++) begin
            if (rd_stat_ev) begin
                pend_nxt[c*RBF_CH_W +: RBF_CH_W] = '0;
            end
            if (load_ev[c]) begin
                pend_nxt[c*RBF_CH_W + RBF_EV_FULL] = 1'b1;
            end
            if (frame_end[c]) begin
                pend_nxt[c*RBF_CH_W + RBF_EV_EOF] = 1'b1;
            end
            if (load_ev[c] && full_r[c] && !rd_ev[c]) begin
                pend_nxt[c*RBF_CH_W + RBF_EV_OVF] = 1'b1;
            end
            if (rd_ev[c] && !full_r[c]) begin
                pend_nxt[c*RBF_CH_W + RBF_EV_UNF] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_r <= '0;
            pend_r <= '0;
        end else begin
            stat_r <= stat_nxt;
            pend_r <= pend_nxt;
        end
    end

    // enable layout matches the pending layout bit for bit
    assign irq = |(pend_r & int_en_r);

endmodule // rbf_top

`default_nettype wire

// *** rbf_top_props.sv ***
// Purpose: port-level checks for rbf_top
// Assumes: one clock domain, reset rst_b active low
// Notes:   bound to every rbf_top instance
`timescale 1ns/1ns
`default_nettype none
module rbf_props
    import rbf_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire rbf_pkg::rbf_bit_s rx_bit_a,
    input wire logic              bit_tick,
    input wire logic              serial_data_pin,
    input wire logic              serial_data_valid_pin,
    input wire logic              byte_mode_select,
    input wire logic              irq
);
    localparam logic [ADDR_W-1:0] ST_A = ADDR_W'(4 * RBF_IDX_STAT);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    ser_off_a: assert property (byte_mode_select |-> !serial_data_pin && !serial_data_valid_pin)
        else $error("serial pins live in byte mode");
    ser_pass_a: assert property (!byte_mode_select |-> serial_data_pin == rx_bit_a.data
        && serial_data_valid_pin == (rx_bit_a.valid && bit_tick)) else $error("serial pins wrong");
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid) else $error("write response late");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
        && s_axi_rdata[31:8] == 24'h000000) else $error("read response wrong");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    ar_stall_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap taken");
    stat_clr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == ST_A && !bit_tick
        && !s_axi_wvalid |=> !irq) else $error("status read left irq");
    irq_cause_a: assert property ($rose(irq) |-> $past(bit_tick) || $past(bit_tick, 2)
        || ($past(s_axi_arvalid) && $past(s_axi_arready)) || s_axi_bvalid)
        else $error("irq without cause");
endmodule // rbf_props
bind rbf_top rbf_props #(.ADDR_W(ADDR_W)) i_rbf_props (
    .clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rx_bit_a(rx_bit_a), .bit_tick(bit_tick), .serial_data_pin(serial_data_pin),
    .serial_data_valid_pin(serial_data_valid_pin), .byte_mode_select(byte_mode_select),
    .irq(irq));
`default_nettype wire

// *** rbf_host_model.sv ***
// Purpose: host side of the bit-serial pins
// Assumes: valid pin qualifies the data pin for one cycle
// Notes:   keeps the last eight bits, first bit ends up highest
`timescale 1ns/1ns
`default_nettype none
module rbf_host_model (
    input  wire logic  clk,
    input  wire logic  rst_b,
    input  wire logic  serial_data_pin,
    input  wire logic  serial_data_valid_pin,
    output logic [7:0] cap_r,
    output int         cnt_r
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cap_r <= 8'h00;
            cnt_r <= 0;
        end else if (serial_data_valid_pin) begin
            cap_r <= {cap_r[6:0], serial_data_pin};
            cnt_r <= cnt_r + 1;
        end
    end
endmodule // rbf_host_model
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench for rbf_top
// Assumes: byte address is four times the register index
// Notes:   integer model of status, data and pending causes per channel
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import rbf_pkg::*;
    localparam logic [7:0] A_CT = 8'(4 * RBF_IDX_CTRL);
    localparam logic [7:0] A_EN = 8'(4 * RBF_IDX_INT_EN);
    localparam logic [7:0] A_ST = 8'(4 * RBF_IDX_STAT);
    localparam logic [7:0] A_DA = 8'(4 * RBF_IDX_DATA_A);
    localparam logic [7:0] A_DB = 8'(4 * RBF_IDX_DATA_B);
    logic clk, awready, wready, bvalid, arready, rvalid, sdp, sdv, bms, irq;
    logic rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, bit_tick = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, cap, ad;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    rbf_bit_s bit_a = 2'b00, bit_b = 2'b00;
    int cnt, err_total, checked, c, sx, lf = 98, gap = 3, en = 0, mode = 1;
    // m_fl is the data register's own full state, apart from the sticky status bit
    int m_sh[2], m_n[2], m_arm[2], m_gc[2], m_dat[2], m_st[2], m_pd[2], m_fl[2];
    rbf_top i_rbf_top (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rx_bit_a(bit_a), .rx_bit_b(bit_b), .bit_tick(bit_tick), .serial_data_pin(sdp),
        .serial_data_valid_pin(sdv), .byte_mode_select(bms), .irq(irq));
    rbf_host_model i_rbf_host_model (.clk(clk), .rst_b(rst_b), .serial_data_pin(sdp),
        .serial_data_valid_pin(sdv), .cap_r(cap), .cnt_r(cnt));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic int lfsr(int s);
        return ((s << 1) | (s[7] ^ s[5] ^ s[4] ^ s[3])) & 255;
    endfunction
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic void m_load(int k, int full);
        if (m_fl[k]) begin
            m_st[k] |= 4;
            m_pd[k] |= 4;
        end
        m_fl[k] = 1;
        m_st[k] = ((m_st[k] | 1) & ~8) | (full << 3);
        m_pd[k] |= 1;
        m_dat[k] = m_sh[k];
        m_sh[k] = 0;
        m_n[k] = 0;
    endfunction
    function automatic void m_bit(int k, int v, int d);
        if (!mode) return;
        if (v) begin
            m_sh[k] = ((m_sh[k] << 1) | d) & 255;
            m_n[k]++;
            m_arm[k] = 1;
            m_gc[k] = 0;
            if (m_n[k] == 8) m_load(k, 1);
        end else if (m_arm[k]) begin
            if (m_gc[k] >= gap) begin
                m_st[k] |= 2;
                m_pd[k] |= 2;
                m_arm[k] = 0;
                if (m_n[k] != 0) m_load(k, 0);
            end else m_gc[k]++;
        end
    endfunction
    function automatic int m_read(logic [7:0] a);
        int k;
        k = (a == A_DB);
        if (a == A_ST) begin
            m_read = m_st[0] | (m_st[1] << 4);
            for (int i = 0; i < 2; i++) begin
                m_st[i] &= 8;
                m_pd[i] = 0;
            end
        end else if (a == A_DA || a == A_DB) begin
            m_read = m_dat[k];
            // a data read empties the register, or flags underflow if already empty; the full bit waits for a status read
            if (m_fl[k]) begin
                m_fl[k] = 0;
            end else begin
                m_st[k] |= 4;
                m_pd[k] |= 8;
            end
        end else m_read = 0;
    endfunction
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        bready <= 1'b0;
        chk("bresp", er, r);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
        logic h, t, s;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        // rready is held back now and then so the slave must hold its answer
        rready <= lf[1];
        do begin
            @(negedge clk);
            h = arvalid && arready;
            s = rvalid;
            t = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (h) arvalid <= 1'b0;
            if (s && !t) rready <= 1'b1;
        end while (!t);
        rready <= 1'b0;
        chk("rdata", ed, d);
        chk("rresp", er, r);
    endtask
    // cycles between ticks put the inverse of the last bit on the data line
    task automatic run(int k, int nv, int ni);
        logic d;
        for (int j = 0; j < nv + ni; j++) begin
            lf = lfsr(lf);
            d = lf[0];
            if (j < nv && k == 0) sx = ((sx << 1) | d) & 255;
            @(posedge clk);
            bit_tick <= 1'b1;
            bit_a <= (k == 0) ? {j < nv, d} : {1'b0, ~d};
            bit_b <= (k == 1) ? {j < nv, d} : {1'b0, ~d};
            m_bit(0, (k == 0) && j < nv, d);
            m_bit(1, (k == 1) && j < nv, d);
            @(posedge clk);
            bit_tick <= 1'b0;
            bit_a <= {1'b0, ~d};
            bit_b <= {1'b0, ~d};
        end
    endtask
    task automatic chk_irq();
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("irq", ((((m_pd[1] << 4) | m_pd[0]) & en) != 0), irq);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        complete_run();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        rd(A_CT, RBF_CTRL_RST, RBF_RESP_OKAY);
        rd(A_EN, 32'h0, RBF_RESP_OKAY);
        chk("mode", RBF_CTRL_RST[RBF_CTRL_MODE_BIT], bms);
        rd(8'h00, 32'h0, RBF_RESP_SLVERR);
        wr(8'h00, 32'hFF, RBF_RESP_SLVERR);
        for (int i = 0; i < 8; i++) begin
            gap = i;
            en = 1 << i;
            c = i / 4;
            ad = c ? A_DB : A_DA;
            wr(A_CT, 8 | i, RBF_RESP_OKAY);
            wr(A_EN, en, RBF_RESP_OKAY);
            rd(A_EN, en, RBF_RESP_OKAY);
            run(c, 0, 2);
            chk_irq();
            run(c, 8, 0);
            chk_irq();
            run(c, 8, 0);
            chk_irq();
            run(c, 3, i + 1);
            chk_irq();
            rd(ad, m_read(ad), RBF_RESP_OKAY);
            rd(ad, m_read(ad), RBF_RESP_OKAY);
            chk_irq();
            wr(A_ST, 1 << (4 * c), RBF_RESP_OKAY);
            m_st[c] &= ~1;
            rd(A_ST, m_read(A_ST), RBF_RESP_OKAY);
            chk_irq();
        end
        wr(A_CT, 32'h02, RBF_RESP_OKAY);
        mode = 0;
        gap = 2;
        chk("mode", 0, bms);
        run(0, 8, 3);
        chk("ser_byte", sx, cap);
        chk("ser_cnt", 8, cnt);
        rd(A_ST, m_read(A_ST), RBF_RESP_OKAY);
        chk_irq();
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
